// [rtl/cies_pkg.sv]
////////////////////////////////////////////////////////////////////////////////
package cies_pkg;

   localparam int unsigned    ADDR_W          = 24;
   localparam logic [7:0]     PAGE_ZERO       = 8'h00;
   localparam logic [7:0]     MARK_FROM_SHORT = 8'h00;
   localparam logic [7:0]     MARK_FROM_LONG  = 8'h01;
   localparam logic [15:0]    NMI_VECTOR      = 16'h0066;
   localparam logic [7:0]     VEC_STEP        = 8'h02;
   localparam logic [2:0]     PUSH_N_SHORT    = 3'h2;
   localparam logic [2:0]     PUSH_N_MIXSHORT = 3'h3;
   localparam logic [2:0]     PUSH_N_LONG     = 3'h3;
   localparam logic [2:0]     PUSH_N_LONGMIX  = 3'h4;
   localparam logic           RST_IEF         = 1'b0;
   localparam logic           RST_MODE_BIT    = 1'b0;
   localparam logic [23:0]    RST_ADDR        = 24'h00_0000;
   localparam logic [7:0]     RST_BYTE        = 8'h00;
   localparam logic [15:0]    ONE_16          = 16'h0001;
   localparam logic [23:0]    ONE_24          = 24'h00_0001;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PUSH,
      ST_RD_LO,
      ST_RD_HI,
      ST_CAP_LO,
      ST_CAP_HI,
      ST_LOAD
   } cies_state_e;

   // {long address mode, mixed mode}
   typedef enum logic [1:0] {
      MODE_SHORT,
      MODE_MIX_SHORT,
      MODE_LONG,
      MODE_LONG_MIX
   } cies_mode_e;

endpackage

// [rtl/cies_prio_pick.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_prio_pick #(
   parameter int unsigned NUM_SRC = 48
) (
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  wire logic [NUM_SRC-1:0]  irq_req_in,
   output var  logic                valid_out,
   output var  logic [7:0]          vector_out
);
   import cies_pkg::*;

   logic       any_d;
   logic [7:0] vec_d;

   // index 0 is scanned last so it wins; the request is a level held by the source
   always_comb begin
      any_d = 1'b0;
      vec_d = RST_BYTE;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (irq_req_in[i]) begin
            any_d = 1'b1;
            vec_d = 8'(i) * VEC_STEP;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         valid_out  <= 1'b0;
         vector_out <= RST_BYTE;
      end else begin
         valid_out  <= any_d;
         vector_out <= vec_d;
      end
   end

   a_lowest_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      irq_req_in[0] |=> valid_out && vector_out == RST_BYTE)
      else $error("source zero did not win");

endmodule
`default_nettype wire

// [rtl/cies_entry_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_entry_seq #(
   parameter int unsigned NUM_SRC = 48
) (
   input  wire logic                        clk_in,
   input  wire logic                        rst_n_in,
   input  wire logic [NUM_SRC-1:0]          irq_req_in,
   input  wire logic                        nmi_n_in,
   input  wire logic                        boundary_in,
   input  wire logic                        mixed_mode_enable_bit_in,
   input  wire logic                        mode_bit_write_in,
   input  wire logic                        mode_bit_value_in,
   input  wire logic                        ief_write_in,
   input  wire logic                        flag_one_value_in,
   input  wire logic                        flag_two_value_in,
   input  wire logic [cies_pkg::ADDR_W-1:0] pc_in,
   input  wire logic [7:0]                  int_page_in,
   input  wire logic [7:0]                  compat_page_base_in,
   input  wire logic [cies_pkg::ADDR_W-1:0] long_stack_pointer_in,
   input  wire logic [15:0]                 short_stack_pointer_in,
   input  wire logic [7:0]                  mem_rdata_in,
   output var  logic [cies_pkg::ADDR_W-1:0] mem_addr_out,
   output var  logic [7:0]                  mem_wdata_out,
   output var  logic                        mem_wr_out,
   output var  logic                        mem_rd_out,
   output var  logic                        busy_out,
   output var  logic                        pc_load_out,
   output var  logic [cies_pkg::ADDR_W-1:0] pc_value_out,
   output var  logic                        long_sp_load_out,
   output var  logic                        short_sp_load_out,
   output var  logic [cies_pkg::ADDR_W-1:0] sp_value_out,
   output var  logic                        int_enable_flag_one_out,
   output var  logic                        int_enable_flag_two_out,
   output var  logic                        long_address_mode_bit_out,
   output var  logic [7:0]                  vector_low_byte_bus_out,
   output var  logic                        nmi_entry_out
);
   import cies_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [23:0] sp_dec(input logic [23:0] sp, input logic long_stack);
      logic [15:0] low;
      low = sp[15:0] - ONE_16;
      sp_dec = long_stack ? (sp - ONE_24) : {sp[23:16], low};
   endfunction

   function automatic cies_mode_e mode_of(input logic long_mode, input logic mixed_mode);
      mode_of = cies_mode_e'({long_mode, mixed_mode});
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // priority pick

   logic       pick_valid;
   logic [7:0] pick_vec;

   cies_prio_pick #(
      .NUM_SRC    (NUM_SRC)
   ) u_pick (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .irq_req_in (irq_req_in),
      .valid_out  (pick_valid),
      .vector_out (pick_vec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // acceptance

   cies_state_e  state_q;
   cies_mode_e   mode_q;
   logic         nmi_armed_q;
   logic         nmi_pend_q;
   logic         take_nmi;
   logic         take_irq;
   logic         take_any;
   cies_mode_e   cur_mode;

   assign cur_mode = mode_of(long_address_mode_bit_out, mixed_mode_enable_bit_in);
   // nmi first and with no flag check; maskable needs the first enable flag
   assign take_nmi = (state_q == ST_IDLE) && boundary_in && nmi_pend_q;
   assign take_irq = (state_q == ST_IDLE) && boundary_in && !nmi_pend_q
                     && pick_valid && int_enable_flag_one_out;
   assign take_any = take_nmi || take_irq;

   // one service per low period: the pin must go high again to re-arm
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         nmi_armed_q <= 1'b0;
         nmi_pend_q  <= 1'b0;
      end else begin
         if (nmi_n_in) begin
            nmi_armed_q <= 1'b1;
         end else if (nmi_pend_q) begin
            nmi_armed_q <= 1'b0;
         end
         if (!nmi_n_in && nmi_armed_q && !nmi_pend_q) begin
            nmi_pend_q <= 1'b1;
         end else if (take_nmi) begin
            nmi_pend_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // entry frame and sequencer

   logic [3:0][7:0] push_buf_q;
   logic [2:0]      push_n_q;
   logic [2:0]      push_idx_q;
   logic [23:0]     sp_work_q;
   logic            long_stack_q;
   logic [23:0]     vec_addr_q;
   logic [7:0]      vec_lo_q;
   logic [7:0]      vec_hi_q;
   logic [7:0]      pc_top_q;
   logic            is_nmi_q;
   logic [23:0]     ret;

   // compatibility mode returns only the 16-bit counter
   assign ret = (cur_mode == MODE_SHORT || cur_mode == MODE_MIX_SHORT)
                ? {PAGE_ZERO, pc_in[15:0]} : pc_in;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q      <= ST_IDLE;
         mode_q       <= MODE_SHORT;
         push_buf_q   <= '0;
         push_n_q     <= '0;
         push_idx_q   <= '0;
         sp_work_q    <= RST_ADDR;
         long_stack_q <= 1'b0;
         vec_addr_q   <= RST_ADDR;
         vec_lo_q     <= RST_BYTE;
         vec_hi_q     <= RST_BYTE;
         pc_top_q     <= RST_BYTE;
         is_nmi_q     <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (take_any) begin
                  state_q    <= ST_PUSH;
                  mode_q     <= cur_mode;
                  is_nmi_q   <= take_nmi;
                  push_idx_q <= '0;
                  unique case (cur_mode)
                     MODE_SHORT: begin
                        push_buf_q   <= {RST_BYTE, RST_BYTE, ret[7:0], ret[15:8]};
                        push_n_q     <= PUSH_N_SHORT;
                        long_stack_q <= 1'b0;
                        sp_work_q    <= {compat_page_base_in, short_stack_pointer_in};
                        vec_addr_q   <= {compat_page_base_in, int_page_in, pick_vec};
                        pc_top_q     <= compat_page_base_in;
                     end
                     MODE_MIX_SHORT: begin
                        push_buf_q   <= {RST_BYTE, MARK_FROM_SHORT, ret[7:0], ret[15:8]};
                        push_n_q     <= PUSH_N_MIXSHORT;
                        long_stack_q <= 1'b1;
                        sp_work_q    <= long_stack_pointer_in;
                        vec_addr_q   <= {PAGE_ZERO, int_page_in, pick_vec};
                        pc_top_q     <= PAGE_ZERO;
                     end
                     MODE_LONG: begin
                        push_buf_q   <= {RST_BYTE, ret[7:0], ret[15:8], ret[23:16]};
                        push_n_q     <= PUSH_N_LONG;
                        long_stack_q <= 1'b1;
                        sp_work_q    <= long_stack_pointer_in;
                        vec_addr_q   <= {PAGE_ZERO, int_page_in, pick_vec};
                        pc_top_q     <= PAGE_ZERO;
                     end
                     MODE_LONG_MIX: begin
                        push_buf_q   <= {MARK_FROM_LONG, ret[7:0], ret[15:8], ret[23:16]};
                        push_n_q     <= PUSH_N_LONGMIX;
                        long_stack_q <= 1'b1;
                        sp_work_q    <= long_stack_pointer_in;
                        vec_addr_q   <= {PAGE_ZERO, int_page_in, pick_vec};
                        pc_top_q     <= PAGE_ZERO;
                     end
                  endcase
               end
            end
            ST_PUSH: begin
               sp_work_q  <= sp_dec(sp_work_q, long_stack_q);
               push_idx_q <= push_idx_q + 3'h1;
               if (push_idx_q == push_n_q - 3'h1) begin
                  state_q <= is_nmi_q ? ST_LOAD : ST_RD_LO;
               end
            end
            ST_RD_LO: state_q <= ST_RD_HI;
            ST_RD_HI: state_q <= ST_CAP_LO;
            ST_CAP_LO: begin
               vec_lo_q <= mem_rdata_in;
               state_q  <= ST_CAP_HI;
            end
            ST_CAP_HI: begin
               vec_hi_q <= mem_rdata_in;
               state_q  <= ST_LOAD;
            end
            ST_LOAD: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory strobes, registered so the bus never sees a combinational glitch

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mem_addr_out  <= RST_ADDR;
         mem_wdata_out <= RST_BYTE;
         mem_wr_out    <= 1'b0;
         mem_rd_out    <= 1'b0;
      end else begin
         mem_wr_out <= 1'b0;
         mem_rd_out <= 1'b0;
         if (state_q == ST_PUSH) begin
            mem_wr_out    <= 1'b1;
            mem_addr_out  <= sp_dec(sp_work_q, long_stack_q);
            mem_wdata_out <= push_buf_q[push_idx_q[1:0]];
         end else if (state_q == ST_RD_LO) begin
            mem_rd_out   <= 1'b1;
            mem_addr_out <= vec_addr_q;
         end else if (state_q == ST_RD_HI) begin
            mem_rd_out   <= 1'b1;
            mem_addr_out <= vec_addr_q + ONE_24;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter, stack pointer and vector bus hand-back

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pc_load_out       <= 1'b0;
         pc_value_out      <= RST_ADDR;
         long_sp_load_out  <= 1'b0;
         short_sp_load_out <= 1'b0;
         sp_value_out      <= RST_ADDR;
         nmi_entry_out     <= 1'b0;
         busy_out          <= 1'b0;
         vector_low_byte_bus_out <= RST_BYTE;
      end else begin
         pc_load_out       <= (state_q == ST_LOAD);
         long_sp_load_out  <= (state_q == ST_LOAD) && long_stack_q;
         short_sp_load_out <= (state_q == ST_LOAD) && !long_stack_q;
         busy_out          <= take_any || (state_q != ST_IDLE && state_q != ST_LOAD);
         if (take_irq) begin
            vector_low_byte_bus_out <= pick_vec;
         end
         if (take_any) begin
            nmi_entry_out <= take_nmi;
         end
         if (state_q == ST_LOAD) begin
            sp_value_out <= sp_work_q;
            // upper byte is 00h outside pure short mode
            pc_value_out <= is_nmi_q ? {pc_top_q, NMI_VECTOR}
                                     : {pc_top_q, vec_hi_q, vec_lo_q};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable flags and address mode

   // entry clear beats a same-cycle software write: the cpu is stalled then anyway
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         int_enable_flag_one_out <= RST_IEF;
         int_enable_flag_two_out <= RST_IEF;
      end else if (take_irq) begin
         int_enable_flag_one_out <= 1'b0;
         int_enable_flag_two_out <= 1'b0;
      end else if (take_nmi) begin
         int_enable_flag_one_out <= 1'b0;
         int_enable_flag_two_out <= int_enable_flag_one_out;
      end else if (ief_write_in && state_q == ST_IDLE) begin
         int_enable_flag_one_out <= flag_one_value_in;
         int_enable_flag_two_out <= flag_two_value_in;
      end
   end

   // handler return style is software's job; on entry this block only sets the mode bit after a mixed short frame
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         long_address_mode_bit_out <= RST_MODE_BIT;
      end else if (state_q == ST_LOAD) begin
         if (mode_q == MODE_MIX_SHORT) begin
            long_address_mode_bit_out <= 1'b1;
         end
      end else if (mode_bit_write_in && state_q == ST_IDLE && !take_any) begin
         long_address_mode_bit_out <= mode_bit_value_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic [2:0] wr_cnt_q;
   logic [7:0] last_wdata_q;
   logic [7:0] first_wdata_q;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_cnt_q      <= '0;
         last_wdata_q  <= RST_BYTE;
         first_wdata_q <= RST_BYTE;
      end else if (take_any) begin
         wr_cnt_q <= '0;
      end else if (mem_wr_out) begin
         wr_cnt_q     <= wr_cnt_q + 3'h1;
         last_wdata_q <= mem_wdata_out;
         if (wr_cnt_q == 3'h0) begin
            first_wdata_q <= mem_wdata_out;
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_read_lo;
      $rose(mem_rd_out);
   endsequence

   sequence s_read_hi;
      mem_rd_out && mem_addr_out == $past(mem_addr_out) + ONE_24 ##1 !mem_rd_out;
   endsequence

   a_irq_clears_ief: assert property (
      take_irq |=> !int_enable_flag_one_out && !int_enable_flag_two_out
                   && vector_low_byte_bus_out == $past(pick_vec))
      else $error("maskable entry left an enable flag set");

   a_vector_lo_hi: assert property (s_read_lo |=> s_read_hi)
      else $error("vector entry not read low then high");

   a_push_count: assert property (
      pc_load_out |-> wr_cnt_q == ((mode_q == MODE_SHORT) ? PUSH_N_SHORT :
                     (mode_q == MODE_LONG_MIX) ? PUSH_N_LONGMIX : PUSH_N_LONG))
      else $error("wrong number of stacked bytes");

   a_short_marker: assert property (
      pc_load_out && mode_q == MODE_MIX_SHORT
      |-> last_wdata_q == MARK_FROM_SHORT && long_address_mode_bit_out)
      else $error("mixed short entry marker or mode bit wrong");

   a_long_marker: assert property (
      pc_load_out && mode_q == MODE_LONG_MIX |-> last_wdata_q == MARK_FROM_LONG)
      else $error("mixed long entry marker wrong");

   a_pc_top_zero: assert property (
      pc_load_out && mode_q != MODE_SHORT |-> pc_value_out[23:16] == PAGE_ZERO)
      else $error("counter top byte not cleared");

   a_ret_top_byte: assert property (
      take_any && cur_mode == MODE_LONG |-> ##3 first_wdata_q == $past(pc_in[23:16], 3))
      else $error("long return address top byte not stacked first");

   a_nmi_no_flags: assert property (
      state_q == ST_IDLE && boundary_in && nmi_pend_q && !int_enable_flag_one_out
      |=> busy_out && nmi_entry_out)
      else $error("non-maskable request not taken");

   // a maskable take here would move the vector bus and zero flag two
   a_nmi_beats_irq: assert property (
      take_nmi && pick_valid && int_enable_flag_one_out
      |=> nmi_entry_out && int_enable_flag_two_out
          && vector_low_byte_bus_out == $past(vector_low_byte_bus_out))
      else $error("maskable request beat a non-maskable one");

   a_short_stack: assert property (
      mem_wr_out && !long_stack_q |-> mem_addr_out[23:16] == sp_work_q[23:16])
      else $error("short stack write left its page");

   a_nmi_level: assert property (
      !nmi_n_in && nmi_armed_q && !nmi_pend_q |=> nmi_pend_q)
      else $error("low pin did not raise a request");

endmodule
`default_nettype wire

// [tb/cies_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_mem_model (
   input  wire logic        clk_in,
   input  wire logic [23:0] mem_addr_in,
   input  wire logic [7:0]  mem_wdata_in,
   input  wire logic        mem_wr_in,
   input  wire logic        mem_rd_in,
   output var  logic [7:0]  mem_rdata_out
);
   // sparse byte store; the bench preloads vector entries and reads back pushes
   logic [7:0] mem [logic [23:0]];

   initial begin
      mem_rdata_out = 8'h5a;
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      if (mem_wr_in) begin
         mem[mem_addr_in] = mem_wdata_in;
      end
      // data only in the cycle after the strobe; otherwise a toggling pattern,
      // so a late sample never sees a stale byte by luck
      if (mem_rd_in) begin
         mem_rdata_out <= mem.exists(mem_addr_in) ? mem[mem_addr_in] : 8'hxx;
      end else begin
         mem_rdata_out <= ~mem_rdata_out;
      end
   end
endmodule
`default_nettype wire

// [tb/cpu_interrupt_entry_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_entry_sequencer_test;
   import cies_pkg::*;
   localparam logic [23:0] PC    = 24'h12_3456;
   localparam logic [23:0] LSP   = 24'h04_0100;
   localparam logic [15:0] SSP   = 16'h8000;
   localparam logic [7:0]  CBASE = 8'h07;
   localparam logic [7:0]  PAGE  = 8'h0b;

   logic        clk_in, rst_n_in, nmi_n_in, boundary_in, mixed_mode_enable_bit_in;
   logic        mode_bit_write_in, mode_bit_value_in, ief_write_in;
   logic        flag_one_value_in, flag_two_value_in;
   logic [47:0] irq_req_in;
   logic [23:0] pc_in, long_stack_pointer_in, mem_addr_out, pc_value_out, sp_value_out;
   logic [7:0]  int_page_in, compat_page_base_in, mem_rdata_in, mem_wdata_out;
   logic [15:0] short_stack_pointer_in;
   logic        mem_wr_out, mem_rd_out, busy_out, pc_load_out, long_sp_load_out;
   logic        short_sp_load_out, int_enable_flag_one_out, int_enable_flag_two_out;
   logic        long_address_mode_bit_out, nmi_entry_out;
   logic [7:0]  vector_low_byte_bus_out;
   int          num_errors, num_checks, m;

   cies_entry_seq uut (.*);
   cies_mem_model mdl (.clk_in(clk_in), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
                       .mem_wr_in(mem_wr_out), .mem_rd_in(mem_rd_out),
                       .mem_rdata_out(mem_rdata_in));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk1(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk24(input string nm, input logic [23:0] e, input logic [23:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one full entry: set mode and flags, raise the request(s), check the result
   task automatic do_entry(input logic lm, input logic mm, input logic nmi, input logic f,
                           input logic [47:0] req, input logic [7:0] vec);
      logic [23:0] stk, va, epc, got;
      logic [7:0]  top;
      logic [7:0]  q[$];
      int          n;
      top = (lm | mm) ? 8'h00 : CBASE;
      stk = (lm | mm) ? LSP : {CBASE, SSP};
      va = {top, PAGE, vec};
      q = {PC[15:8], PC[7:0]};
      if (lm) q.push_front(PC[23:16]);
      if (mm) q.push_back(lm ? 8'h01 : 8'h00);
      epc = nmi ? {top, NMI_VECTOR} : {top, 8'h80 | vec, vec ^ 8'hff};
      mdl.mem.delete();
      mdl.mem[va] = vec ^ 8'hff;
      mdl.mem[va + 24'h00_0001] = 8'h80 | vec;
      @(posedge clk_in);
      mode_bit_write_in <= 1'b1;
      mode_bit_value_in <= lm;
      ief_write_in <= 1'b1;
      flag_one_value_in <= f;
      flag_two_value_in <= f;
      mixed_mode_enable_bit_in <= mm;
      nmi_n_in <= ~nmi;
      // raised with the pin so that both are pending at the take edge
      irq_req_in <= req;
      @(posedge clk_in);
      mode_bit_write_in <= 1'b0;
      ief_write_in <= 1'b0;
      boundary_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (pc_load_out !== 1'b1 && n < 60);
      chk1("pc_load", 1'b1, pc_load_out);
      chk24("pc_value", epc, pc_value_out);
      chk24("sp_value", stk - 24'(q.size()), sp_value_out);
      chk1("long_sp_load", lm | mm, long_sp_load_out);
      chk1("short_sp_load", ~(lm | mm), short_sp_load_out);
      @(posedge clk_in);
      irq_req_in <= '0;
      nmi_n_in <= 1'b1;
      boundary_in <= 1'b0;
      @(posedge clk_in);
      #1;
      chk1("busy", 1'b0, busy_out);
      chk1("mode_bit", lm | mm, long_address_mode_bit_out);
      chk1("flag_one", 1'b0, int_enable_flag_one_out);
      chk1("flag_two", nmi & f, int_enable_flag_two_out);
      chk1("nmi_entry", nmi, nmi_entry_out);
      if (!nmi) chk24("vector_bus", {16'h0000, vec}, {16'h0000, vector_low_byte_bus_out});
      foreach (q[i]) begin
         va = stk - 24'(i + 1);
         got = mdl.mem.exists(va) ? {16'h0000, mdl.mem[va]} : 24'hxx_xxxx;
         chk24("stack_byte", {16'h0000, q[i]}, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // an entry takes at most 14 cycles; this leaves a wide margin
   initial begin
      repeat (5000) @(posedge clk_in);
      num_errors++;
      final_report();
   end

   initial begin
      num_errors = 0;
      num_checks = 0;
      rst_n_in = 1'b0;
      nmi_n_in = 1'b1;
      boundary_in = 1'b0;
      mixed_mode_enable_bit_in = 1'b0;
      mode_bit_write_in = 1'b0;
      mode_bit_value_in = 1'b0;
      ief_write_in = 1'b0;
      flag_one_value_in = 1'b0;
      flag_two_value_in = 1'b0;
      irq_req_in = '0;
      pc_in = PC;
      long_stack_pointer_in = LSP;
      short_stack_pointer_in = SSP;
      int_page_in = PAGE;
      compat_page_base_in = CBASE;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      #1;
      chk1("busy_rst", 1'b0, busy_out);
      chk1("mode_rst", 1'b0, long_address_mode_bit_out);
      chk1("flag_rst", 1'b0, int_enable_flag_one_out);
      for (m = 0; m < 4; m++) begin
         do_entry(m[1], m[0], 1'b0, 1'b1, 48'h0000_0000_0020, 8'h0a);
      end
      do_entry(1'b1, 1'b0, 1'b0, 1'b1, 48'h0000_0000_0088, 8'h06);
      // flag one clear: a maskable request must be left waiting
      @(posedge clk_in);
      ief_write_in <= 1'b1;
      flag_one_value_in <= 1'b0;
      flag_two_value_in <= 1'b0;
      @(posedge clk_in);
      ief_write_in <= 1'b0;
      irq_req_in <= 48'h0000_0000_0001;
      boundary_in <= 1'b1;
      repeat (8) begin
         @(posedge clk_in);
         #1;
         chk1("busy_masked", 1'b0, busy_out);
      end
      @(posedge clk_in);
      irq_req_in <= '0;
      boundary_in <= 1'b0;
      do_entry(1'b0, 1'b1, 1'b1, 1'b0, 48'h0000_0000_0001, 8'h00);
      do_entry(1'b1, 1'b1, 1'b1, 1'b1, 48'h0000_0000_0002, 8'h00);
      do_entry(1'b0, 1'b0, 1'b1, 1'b1, 48'h0000_0000_0000, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
